// File: verilog/bfs_top.sv
// Functional notes
// - Mode bit selects single or three pole
// - Supervised initiate needs current above supervision level
// - Seal-in holds only while current stays above
// - Three-pole initiate operand starts all poles
// - One phase level for initiate and seal-in
// - Neutral levels used only in three-pole mode
// - Early path only when enabled
// - Main path, no contact, only when enabled
// - Slow path, no current check, only when enabled
// - Early contact per pole, pole A in three-pole
// - Normal contact input separate from early contact
// - Out-of-service operand input
// - Hi-set level supervises after early/main timeout
// - Lower lo-set level after resistor insertion
// - Neutral hi/lo levels only in three-pole mode
// - Lo-set enabled after delay from hi-set
// - Zone trip held for programmable dropout period
// - Three per-pole initiate operands in single-pole
// - Logic replicated per pole, shared levels
// - Re-trip only the initiated pole
// - Single-pole failure gives three-pole zone trip
// - Magnitude lag covered by timer margins
// - Slow delay is main delay plus margin
// - Path timers 0 to 65535 ms
// - Re-trip asserted at once on initiation
// - Early fail needs contact closed and current
// - Slow path blocked out of service, contact supervised
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module bfs_top
   import bfs_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = bfs_pkg::TICK_CYC
) (
   // Clock and reset
   input  wire logic                      clock,
   input  wire logic                      rst_n,
   // AHB-Lite slave
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic                           hreadyout,
   output logic [31:0]                    hrdata,
   output logic                           hresp,
   // Protection operands, same clock
   input  wire logic                      three_pole_initiate_in,
   input  wire logic                      pole_a_initiate_in,
   input  wire logic                      pole_b_initiate_in,
   input  wire logic                      pole_c_initiate_in,
   // Measured magnitudes, same clock
   input  wire logic [bfs_pkg::CUR_W-1:0] phase_mag_a,
   input  wire logic [bfs_pkg::CUR_W-1:0] phase_mag_b,
   input  wire logic [bfs_pkg::CUR_W-1:0] phase_mag_c,
   input  wire logic [bfs_pkg::CUR_W-1:0] neutral_mag,
   // Breaker contacts and service switch, asynchronous
   input  wire logic [2:0]                early_contact_in,
   input  wire logic [2:0]                normal_contact_in,
   input  wire logic                      out_of_service_in,
   // Trip outputs
   output logic [2:0]                     retrip_out,
   output logic                           zone_trip_out,
   output logic                           failed_breaker_out
);
   import bfs_pkg::*;

   // Whole block state
   typedef struct packed {
      bfs_dp_t                     dp;
      logic [7:0]                  dp_addr;
      logic [31:0]                 rdata;
      logic [5:0]                  ctrl;
      logic [5:0][CUR_W-1:0]       lvl;
      logic [4:0][DLY_W-1:0]       dly;
      logic [TICK_W-1:0]           tick_cnt;
      logic                        tick;
      logic [2:0]                  seal;
      logic [2:0]                  retrip;
      logic                        zone;
      logic                        failed;
      logic [DLY_W-1:0]            hold_cnt;
   } bfs_top_st_t;

   bfs_top_st_t st_ff;
   bfs_top_st_t nxt_st;

   // Synchronised pins
   logic [2:0]       early_c;             // Early contacts
   logic [2:0]       normal_c;            // Normal contacts
   logic             oos;                 // Out of service
   // Scheme nets
   logic             single;              // Single-pole mode
   logic [2:0]       pinit;               // Initiate per pole
   logic [2:0]       init_ok;             // Initiate after supervision
   logic [2:0]       active;              // Initiated or sealed
   logic [2:0]       supv_ov;             // Supervision level exceeded
   logic [2:0]       hi_ov;               // Hi-set exceeded
   logic [2:0]       lo_ov;               // Lo-set exceeded
   logic [2:0]       cur_ok;              // Output supervision met
   logic [2:0]       f_early;             // Early path failure
   logic [2:0]       f_main;              // Main path failure
   logic [2:0]       f_slow;              // Slow path failure
   logic             fail_any;            // Any pole failed
   logic [2:0][3:0]  t_run;               // Timer run per pole/path
   logic [2:0][3:0]  t_done;              // Timer done per pole/path
   logic             bus_take;            // Address phase accepted
   logic [31:0]      rd_mux;              // Read data mux

   // Pins cross into the clock domain
   bfs_sync2 #(.W(7)) u_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in ({out_of_service_in, normal_contact_in, early_contact_in}),
      .sync_out ({oos, normal_c, early_c})
   );

   // Magnitude above level for a pole; neutral only counts in three-pole
   function automatic logic pole_over(input logic sp, input logic [2:0] ph,
                                      input logic n, input int p);
      pole_over = sp ? ph[p] : ((|ph) | n);
   endfunction

   // Level comparison on all phases
   function automatic logic [2:0] ph_over(input logic [CUR_W-1:0] lv,
                                          input logic [CUR_W-1:0] a,
                                          input logic [CUR_W-1:0] b,
                                          input logic [CUR_W-1:0] c);
      ph_over = {c > lv, b > lv, a > lv};
   endfunction

   // Per-pole path timers
   // Delays are whole ticks, so each setting must already hold
   // the magnitude decay lag and the slow path's extra margin
   for (genvar p = 0; p < 3; p++) begin : g_pole
      for (genvar k = 0; k < 4; k++) begin : g_tmr
         bfs_delay_timer #(.DW(DLY_W)) u_tmr (
            .clock (clock),
            .rst_n (rst_n),
            .run   (t_run[p][k]),
            .tick  (st_ff.tick),
            .delay (st_ff.dly[k]),
            .done  (t_done[p][k])
         );
      end
   end

   // Protection scheme, per pole
   always_comb begin
      logic [2:0] ph_s;
      logic [2:0] ph_h;
      logic [2:0] ph_l;
      // Phase currents against the shared levels
      ph_s = ph_over(st_ff.lvl[LV_PH_SUPV], phase_mag_a, phase_mag_b, phase_mag_c);
      ph_h = ph_over(st_ff.lvl[LV_PH_HI], phase_mag_a, phase_mag_b, phase_mag_c);
      ph_l = ph_over(st_ff.lvl[LV_PH_LO], phase_mag_a, phase_mag_b, phase_mag_c);
      single = st_ff.ctrl[CTRL_MODE];
      // Timers stay idle unless a path runs them
      t_run = '0;
      for (int p = 0; p < 3; p++) begin
         // Neutral ignored in single-pole mode
         supv_ov[p] = pole_over(single, ph_s, neutral_mag > st_ff.lvl[LV_N_SUPV], p);
         hi_ov[p] = pole_over(single, ph_h, neutral_mag > st_ff.lvl[LV_N_HI], p);
         lo_ov[p] = pole_over(single, ph_l, neutral_mag > st_ff.lvl[LV_N_LO], p);

         // Three-pole operand starts every pole
         pinit[p] = three_pole_initiate_in | (single & (p == 0 ? pole_a_initiate_in :
                    p == 1 ? pole_b_initiate_in : pole_c_initiate_in));
         init_ok[p] = pinit[p] & (!st_ff.ctrl[CTRL_AMP] | supv_ov[p]);
         active[p] = init_ok[p] | st_ff.seal[p];

         // Paths timed independently per pole
         t_run[p][DL_EARLY] = active[p] & st_ff.ctrl[CTRL_EARLY];
         t_run[p][DL_MAIN] = active[p] & st_ff.ctrl[CTRL_MAIN];
         t_run[p][DL_SLOW] = active[p] & st_ff.ctrl[CTRL_SLOW] & !oos;
         // Lo-set timer starts with the hi-set detector
         t_run[p][DL_LO] = t_done[p][DL_EARLY] | t_done[p][DL_MAIN];
         // Hi-set first, lo-set once its delay ends
         cur_ok[p] = t_done[p][DL_LO] ? lo_ov[p] : hi_ov[p];

         // Contact operands: pole A serves all poles in three-pole mode
         f_early[p] = t_done[p][DL_EARLY] & (single ? early_c[p] : early_c[0]) & cur_ok[p];
         f_main[p] = t_done[p][DL_MAIN] & cur_ok[p];
         f_slow[p] = t_done[p][DL_SLOW] & (single ? normal_c[p] : normal_c[0]);
      end
      // Every pole and path feeds the one zone trip
      fail_any = |(f_early | f_main | f_slow);
   end

   // Register read mux
   always_comb begin
      logic [7:0] a;
      a = st_ff.dp_addr;
      // Unmapped words read as zero
      rd_mux = '0;
      if (a == ADDR_CTRL) begin
         rd_mux[5:0] = st_ff.ctrl;
      end else if (a >= ADDR_PH_SUPV && a <= ADDR_N_LO) begin
         rd_mux[CUR_W-1:0] = st_ff.lvl[3'((a - ADDR_PH_SUPV) >> 2)];
      end else if (a >= ADDR_T_EARLY && a <= ADDR_T_HOLD) begin
         rd_mux[DLY_W-1:0] = st_ff.dly[3'((a - ADDR_T_EARLY) >> 2)];
      end else if (a == ADDR_STATUS) begin
         rd_mux[ST_RETRIP +: 3] = st_ff.retrip;
         rd_mux[ST_ZONE] = st_ff.zone;
         rd_mux[ST_FAILED] = st_ff.failed;
         rd_mux[ST_SEAL +: 3] = st_ff.seal;
      end
   end

   assign bus_take = hsel & htrans[1] & hready;

   // Next state: bus, registers, tick, trip outputs
   always_comb begin
      logic [7:0] a;
      logic       clr;
      a = st_ff.dp_addr;
      clr = 1'b0;
      // Registers keep their value unless written below
      nxt_st = st_ff;
      // Data phase of the bus
      case (st_ff.dp)
         DP_WRITE: begin
            if (a == ADDR_CTRL) begin
               nxt_st.ctrl = hwdata[5:0];
            end else if (a >= ADDR_PH_SUPV && a <= ADDR_N_LO) begin
               nxt_st.lvl[3'((a - ADDR_PH_SUPV) >> 2)] = hwdata[CUR_W-1:0];
            end else if (a >= ADDR_T_EARLY && a <= ADDR_T_HOLD) begin
               nxt_st.dly[3'((a - ADDR_T_EARLY) >> 2)] = hwdata[DLY_W-1:0];
            end else if (a == ADDR_STATUS) begin
               clr = hwdata[ST_FAILED];
            end
         end
         DP_RDWAIT: begin
            nxt_st.rdata = rd_mux;
         end
         default: begin
         end
      endcase

      // Next data phase
      if (bus_take) begin
         nxt_st.dp = hwrite ? DP_WRITE : DP_RDWAIT;
         nxt_st.dp_addr = {haddr[7:2], 2'b00};
      end else if (st_ff.dp == DP_RDWAIT) begin
         nxt_st.dp = DP_RDDONE;
      end else begin
         nxt_st.dp = DP_IDLE;
      end

      // One millisecond tick
      nxt_st.tick = 1'b0;
      if (st_ff.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
         nxt_st.tick_cnt = '0;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.tick_cnt = TICK_W'(st_ff.tick_cnt + 1'b1);
      end

      // Seal-in drops as soon as current falls
      nxt_st.seal = {3{st_ff.ctrl[CTRL_SEAL]}} & supv_ov & active;
      nxt_st.retrip = active;

      // Zone trip sealed for the hold period
      if (fail_any) begin
         nxt_st.hold_cnt = st_ff.dly[DL_HOLD];
      end else if (st_ff.tick && st_ff.hold_cnt != '0) begin
         nxt_st.hold_cnt = DLY_W'(st_ff.hold_cnt - 1'b1);
      end
      nxt_st.zone = fail_any | (st_ff.hold_cnt != '0);

      // Failure flag: a new failure beats the clear
      nxt_st.failed = fail_any | (st_ff.failed & !clr);
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.ctrl <= RST_CTRL;
         st_ff.lvl <= {6{RST_LEVEL}};
         st_ff.dly <= {5{RST_DELAY}};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs
   assign hreadyout = (st_ff.dp != DP_RDWAIT);
   assign hrdata = st_ff.rdata;
   assign hresp = 1'b0;
   assign retrip_out = st_ff.retrip;
   assign zone_trip_out = st_ff.zone;
   assign failed_breaker_out = st_ff.failed;

   // Checks on the one clock, quiet during reset
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_three_init;
      three_pole_initiate_in && !st_ff.ctrl[CTRL_AMP];
   endsequence

   a_retrip_three: assert property (s_three_init |=> retrip_out == 3'h7)
      else $error("retrip missing after three-pole initiate");
   a_amp_block: assert property (st_ff.ctrl[CTRL_AMP] && supv_ov == 3'h0
      && st_ff.seal == 3'h0 |=> retrip_out == 3'h0)
      else $error("initiate not blocked without current");
   a_pole_only: assert property (single && !three_pole_initiate_in && pole_a_initiate_in
      && !pole_b_initiate_in && !pole_c_initiate_in && !st_ff.ctrl[CTRL_AMP]
      && st_ff.seal == 3'h0 |=> retrip_out == 3'h1)
      else $error("wrong pole retripped");
   a_early_off: assert property (!st_ff.ctrl[CTRL_EARLY] |-> f_early == 3'h0)
      else $error("disabled early path failed");
   a_main_off: assert property (!st_ff.ctrl[CTRL_MAIN] |-> f_main == 3'h0)
      else $error("disabled main path failed");
   a_slow_oos: assert property (oos || !st_ff.ctrl[CTRL_SLOW] |-> f_slow == 3'h0)
      else $error("slow path ran while blocked");
   a_fail_trip: assert property (fail_any |=> zone_trip_out && failed_breaker_out)
      else $error("failure without zone trip");
   a_zone_hold: assert property (zone_trip_out && !fail_any && st_ff.hold_cnt != '0
      |=> zone_trip_out)
      else $error("zone trip dropped early");
   a_neutral_sp: assert property (single && phase_mag_a == '0 |-> !supv_ov[0])
      else $error("neutral used in single-pole");

   // Seal-in release and output supervision
   sequence s_seal_no_cur;
      st_ff.seal != 3'h0 && supv_ov == 3'h0;
   endsequence

   a_seal_drop: assert property (s_seal_no_cur |=> st_ff.seal == 3'h0)
      else $error("seal-in held without current");
   a_hiset_first: assert property (!t_done[0][DL_LO] |-> cur_ok[0] == hi_ov[0])
      else $error("lo-set used before its delay");

   // Tick and sticky flag
   a_tick_single: assert property (st_ff.tick |=> !st_ff.tick)
      else $error("tick longer than one clock");
   a_flag_hold: assert property (failed_breaker_out && st_ff.dp != DP_WRITE |=> failed_breaker_out)
      else $error("failed flag dropped without a clear");

endmodule
`default_nettype wire

// File: verilog/bfs_pkg.sv
package bfs_pkg;

   // Clock and protection tick timing
   localparam int unsigned CLK_PERIOD_NS  = 4;
   localparam int unsigned TICK_PERIOD_NS = 1000000;
   localparam int unsigned TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int          TICK_W         = 18;

   // Data widths of magnitudes, levels and delays
   localparam int CUR_W = 16;
   localparam int DLY_W = 16;

   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_PH_SUPV = 8'h04;
   localparam logic [7:0] ADDR_N_LO    = 8'h18;
   localparam logic [7:0] ADDR_T_EARLY = 8'h1C;
   localparam logic [7:0] ADDR_T_HOLD  = 8'h2C;
   localparam logic [7:0] ADDR_STATUS  = 8'h30;

   // Level slots, in offset order from ADDR_PH_SUPV
   localparam int LV_PH_SUPV = 0;
   localparam int LV_N_SUPV  = 1;
   localparam int LV_PH_HI   = 2;
   localparam int LV_N_HI    = 3;
   localparam int LV_PH_LO   = 4;
   localparam int LV_N_LO    = 5;

   // Delay slots, in offset order from ADDR_T_EARLY
   localparam int DL_EARLY = 0;
   localparam int DL_MAIN  = 1;
   localparam int DL_SLOW  = 2;
   localparam int DL_LO    = 3;
   localparam int DL_HOLD  = 4;

   // Control bits
   localparam int CTRL_MODE  = 0;
   localparam int CTRL_AMP   = 1;
   localparam int CTRL_SEAL  = 2;
   localparam int CTRL_EARLY = 3;
   localparam int CTRL_MAIN  = 4;
   localparam int CTRL_SLOW  = 5;

   // Status bits
   localparam int ST_RETRIP = 0;
   localparam int ST_ZONE   = 3;
   localparam int ST_FAILED = 4;
   localparam int ST_SEAL   = 5;

   // Values after reset
   localparam logic [5:0]       RST_CTRL  = 6'h38;
   localparam logic [CUR_W-1:0] RST_LEVEL = 16'h041A;
   localparam logic [DLY_W-1:0] RST_DELAY = 16'h0000;

   // Bus data phase states
   typedef enum logic [1:0] {DP_IDLE, DP_WRITE, DP_RDWAIT, DP_RDDONE} bfs_dp_t;

endpackage

// File: verilog/bfs_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module bfs_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst_n,
   // Levels in and out
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   // Two stages; the first is read only by the second
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } bfs_sync_st_t;

   bfs_sync_st_t st_ff;
   bfs_sync_st_t nxt_st;

   // Shift the pin level through both stages
   always_comb begin
      nxt_st.s1 = async_in;
      nxt_st.s2 = st_ff.s1;
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sync_out = st_ff.s2;

endmodule
`default_nettype wire

// File: verilog/bfs_delay_timer.sv
`timescale 1ns/1ns
`default_nettype none
module bfs_delay_timer #(
   parameter int DW = 16
) (
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst_n,
   // Run level, tick pulse, delay in ticks
   input  wire logic          run,
   input  wire logic          tick,
   input  wire logic [DW-1:0] delay,
   // Delay has elapsed while running
   output logic               done
);

   typedef struct packed {
      logic [DW-1:0] cnt;
   } bfs_tmr_st_t;

   bfs_tmr_st_t st_ff;
   bfs_tmr_st_t nxt_st;

   // Count ticks while running, restart whenever run drops
   always_comb begin
      nxt_st = st_ff;
      if (!run) begin
         nxt_st.cnt = '0;
      end else if (tick && st_ff.cnt < delay) begin
         nxt_st.cnt = DW'(st_ff.cnt + 1'b1);
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // A zero delay is done as soon as run rises
   assign done = run && (st_ff.cnt >= delay);

endmodule
`default_nettype wire

// File: verif/bfs_breaker_model.sv
`timescale 1ns/1ns
`default_nettype none
module bfs_breaker_model #(
   parameter int OPEN_CYC = 6
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Re-trip command and stuck-pole request
   input  wire logic [2:0] trip,
   input  wire logic [2:0] stuck,
   // Closed-indicating contacts, high while closed
   output logic      [2:0] early_contact,
   output logic      [2:0] normal_contact
);
   // Cycles each pole has been driven open
   int cnt [3];

   // A stuck pole never moves; the early contact leaves one cycle first
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt            <= '{0, 0, 0};
         early_contact  <= 3'h7;
         normal_contact <= 3'h7;
      end else begin
         for (int p = 0; p < 3; p++) begin
            cnt[p]            <= (trip[p] && !stuck[p]) ? cnt[p] + 1 : 0;
            early_contact[p]  <= !(cnt[p] >= OPEN_CYC - 1);
            normal_contact[p] <= !(cnt[p] >= OPEN_CYC);
         end
      end
   end
endmodule
`default_nettype wire

// File: verif/bfs_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module bfs_top_tb_top;
   import bfs_pkg::*;
   // Clock, reset and bus
   logic             clock  = 1'b0;
   logic             rst_n  = 1'b0;
   logic             hsel   = 1'b0;
   logic      [31:0] haddr  = 32'h0;
   logic      [1:0]  htrans = 2'h0;
   logic             hwrite = 1'b0;
   logic      [31:0] hwdata = 32'h0;
   logic             hready;
   logic             hreadyout;
   logic      [31:0] hrdata;
   logic             hresp;
   // Operands and magnitudes
   logic             tp_init   = 1'b0;
   logic      [2:0]  pole_init = 3'h0;
   logic [CUR_W-1:0] mag_a     = '0;
   logic [CUR_W-1:0] mag_n     = '0;
   logic             oos       = 1'b0;
   logic      [2:0]  stuck     = 3'h0;
   // Contacts and trip outputs
   logic      [2:0]  early_c;
   logic      [2:0]  normal_c;
   logic      [2:0]  retrip_out;
   logic             zone_trip_out;
   logic             failed_breaker_out;
   // Score
   int               bad_count  = 0;
   int               num_checks = 0;

   assign hready = hreadyout;

   // Clock of 4 ns
   always #2 clock = ~clock;

   bfs_top #(.TICK_CYCLES(4)) uut (
      .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .three_pole_initiate_in(tp_init), .pole_a_initiate_in(pole_init[0]),
      .pole_b_initiate_in(pole_init[1]), .pole_c_initiate_in(pole_init[2]),
      .phase_mag_a(mag_a), .phase_mag_b(mag_a), .phase_mag_c(mag_a), .neutral_mag(mag_n),
      .early_contact_in(early_c), .normal_contact_in(normal_c), .out_of_service_in(oos),
      .retrip_out(retrip_out), .zone_trip_out(zone_trip_out),
      .failed_breaker_out(failed_breaker_out));

   // Breaker at the far side
   bfs_breaker_model brk (
      .clock(clock), .rst_n(rst_n), .trip(retrip_out), .stuck(stuck),
      .early_contact(early_c), .normal_contact(normal_c));

   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // One comparison
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Wait until the coming edge samples hready high
   task automatic wait_ready();
      int n;
      for (n = 0; n < 20; n++) begin
         @(negedge clock);
         if (hreadyout === 1'b1) break;
      end
      if (n == 20) begin
         check("hready timeout", 32'h0, 32'h1);
         finish_test();
      end
   endtask

   // Single AHB-Lite word transfer; returns at the settled end of the data phase
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clock);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      @(posedge clock);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   // Drive operands just after an edge
   task automatic fire(input logic tp, input logic [2:0] pi, input logic [15:0] ma, input logic [15:0] mn);
      @(posedge clock);
      tp_init   <= tp;
      pole_init <= pi;
      mag_a     <= ma;
      mag_n     <= mn;
   endtask

   // Let edges pass, then look between edges
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask

   // Quiet inputs, clear the flag, load a control word
   task automatic rest(input logic [7:0] ctrl);
      logic [31:0] d;
      fire(1'b0, 3'h0, 16'h0, 16'h0);
      oos   <= 1'b0;
      stuck <= 3'h0;
      repeat (40) @(posedge clock);
      ahb(ADDR_STATUS, 1'b1, 32'h1 << ST_FAILED, d);
      ahb(ADDR_CTRL, 1'b1, {24'h0, ctrl}, d);
      check("zone idle", 32'(zone_trip_out), 32'h0);
      check("failed cleared", 32'(failed_breaker_out), 32'h0);
   endtask

   // Reset values and an unmapped place
   task automatic t_regs();
      logic [31:0] d;
      ahb(ADDR_CTRL, 1'b0, 32'h0, d);
      check("ctrl reset", d, 32'h38);
      ahb(ADDR_PH_SUPV, 1'b0, 32'h0, d);
      check("phase supv reset", d, 32'h41A);
      ahb(ADDR_N_LO, 1'b0, 32'h0, d);
      check("neutral lo reset", d, 32'h41A);
      ahb(ADDR_T_HOLD, 1'b0, 32'h0, d);
      check("hold reset", d, 32'h0);
      ahb(8'h3C, 1'b1, 32'hFFFF, d);
      ahb(8'h3C, 1'b0, 32'h0, d);
      check("unmapped", d, 32'h0);
      check("hresp", 32'(hresp), 32'h0);
      $display("test regs done");
   endtask

   // Three-pole initiate with no supervision and zero delays
   task automatic t_basic();
      logic [31:0] d;
      rest(8'h38);
      fire(1'b1, 3'h0, 16'd2000, 16'h0);
      settle(1);
      check("retrip", 32'(retrip_out), 32'h7);
      settle(2);
      check("zone", 32'(zone_trip_out), 32'h1);
      check("failed", 32'(failed_breaker_out), 32'h1);
      ahb(ADDR_STATUS, 1'b0, 32'h0, d);
      check("status", d & 32'h1F, 32'h1F);
      $display("test basic done");
   endtask

   // Supervised initiate on phase, then neutral per mode
   task automatic t_supv();
      logic [31:0] d;
      rest(8'h3A);
      ahb(ADDR_PH_SUPV, 1'b1, 32'd500, d);
      fire(1'b1, 3'h0, 16'd500, 16'h0);
      settle(3);
      check("retrip at level", 32'(retrip_out), 32'h0);
      fire(1'b1, 3'h0, 16'd501, 16'h0);
      settle(1);
      check("retrip above level", 32'(retrip_out), 32'h7);
      ahb(ADDR_PH_SUPV, 1'b1, 32'h41A, d);
      rest(8'h3B);
      fire(1'b0, 3'h1, 16'h0, 16'd2000);
      settle(3);
      check("neutral single pole", 32'(retrip_out), 32'h0);
      rest(8'h3A);
      fire(1'b1, 3'h0, 16'h0, 16'd2000);
      settle(1);
      check("neutral three pole", 32'(retrip_out), 32'h7);
      $display("test supv done");
   endtask

   // Each pole alone in single-pole mode, pole C refused in three-pole mode
   task automatic t_poles();
      for (int p = 0; p < 3; p++) begin
         rest(8'h39);
         fire(1'b0, 3'(1 << p), 16'd2000, 16'h0);
         settle(1);
         check("pole retrip", 32'(retrip_out), 32'(1 << p));
         settle(2);
         check("pole zone", 32'(zone_trip_out), 32'h1);
      end
      rest(8'h38);
      fire(1'b0, 3'h4, 16'd2000, 16'h0);
      settle(3);
      check("pole ignored", 32'(retrip_out), 32'h0);
      $display("test poles done");
   endtask

   // Seal-in holds with current, releases without
   task automatic t_seal();
      rest(8'h3C);
      fire(1'b1, 3'h0, 16'd2000, 16'h0);
      fire(1'b0, 3'h0, 16'd2000, 16'h0);
      settle(3);
      check("sealed", 32'(retrip_out), 32'h7);
      fire(1'b0, 3'h0, 16'h0, 16'h0);
      settle(3);
      check("seal released", 32'(retrip_out), 32'h0);
      $display("test seal done");
   endtask

   // Zone trip stays for the hold period of 4 ticks
   task automatic t_hold();
      logic [31:0] d;
      rest(8'h38);
      ahb(ADDR_T_HOLD, 1'b1, 32'h4, d);
      fire(1'b1, 3'h0, 16'd2000, 16'h0);
      settle(3);
      check("zone on", 32'(zone_trip_out), 32'h1);
      fire(1'b0, 3'h0, 16'h0, 16'h0);
      settle(8);
      check("zone held", 32'(zone_trip_out), 32'h1);
      settle(20);
      check("zone dropped", 32'(zone_trip_out), 32'h0);
      ahb(ADDR_T_HOLD, 1'b1, 32'h0, d);
      $display("test hold done");
   endtask

   // One path alone with a delay of 4 ticks
   task automatic path(input logic [7:0] ctrl, input int slot, input logic [15:0] ma,
                       input logic o, input logic [2:0] s, input logic exp);
      logic [31:0] d;
      rest(ctrl);
      ahb(ADDR_T_EARLY + 8'(4 * slot), 1'b1, 32'h4, d);
      @(posedge clock);
      oos   <= o;
      stuck <= s;
      fire(1'b1, 3'h0, ma, 16'h0);
      settle(40);
      check("path zone", 32'(zone_trip_out), 32'(exp));
   endtask

   // Path enables, contact, current and service supervision
   task automatic t_paths();
      path(8'h08, DL_EARLY, 16'd2000, 1'b0, 3'h0, 1'b0);
      path(8'h08, DL_EARLY, 16'd2000, 1'b0, 3'h7, 1'b1);
      path(8'h00, DL_EARLY, 16'd2000, 1'b0, 3'h7, 1'b0);
      path(8'h10, DL_MAIN, 16'd2000, 1'b0, 3'h0, 1'b1);
      path(8'h10, DL_MAIN, 16'h0, 1'b0, 3'h7, 1'b0);
      path(8'h20, DL_SLOW, 16'h0, 1'b0, 3'h7, 1'b1);
      path(8'h20, DL_SLOW, 16'h0, 1'b1, 3'h7, 1'b0);
      path(8'h20, DL_SLOW, 16'h0, 1'b0, 3'h0, 1'b0);
      $display("test paths done");
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      t_regs();
      t_basic();
      t_supv();
      t_poles();
      t_seal();
      t_hold();
      t_paths();
      finish_test();
   end
endmodule
`default_nettype wire
